//--- core/adcctl_defs.svh
// Constants for the control-byte decoder and track/hold sequencer.
// Assumes inclusion by core files only.
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH
`define ADCCTL_BIT_START     3'd7
`define ADCCTL_BIT_SEL_MSB   3'd6
`define ADCCTL_BIT_SEL_LSB   3'd4
`define ADCCTL_BIT_POLARITY  3'd3
`define ADCCTL_BIT_INCONFIG  3'd2
`define ADCCTL_BYTE_BITS     4'd8
`define ADCCTL_TRACK_AFTER   4'd5
`define ADCCTL_CTRL_RESET    8'h00
`define ADCCTL_TACQ_NS       1500
`define ADCCTL_CLK_NS        10
`define ADCCTL_TACQ_CYC      ((`ADCCTL_TACQ_NS + `ADCCTL_CLK_NS - 1) / `ADCCTL_CLK_NS)
`endif

//--- core/adcctl_pkg.sv
// Types for the control-byte decoder and track/hold sequencer.
// Assumes nothing of its surroundings.
package adcctl_pkg;
  typedef enum logic [1:0] {
    ADCCTL_IDLE  = 2'b00,
    ADCCTL_SHIFT = 2'b01,
    ADCCTL_HOLD  = 2'b10
  } adcctl_state_t;
  typedef enum logic [1:0] {
    ADCCTL_NEG_COM = 2'b00,
    ADCCTL_NEG_CH0 = 2'b01,
    ADCCTL_NEG_CH1 = 2'b10,
    ADCCTL_NEG_CH2 = 2'b11
  } adcctl_neg_t;
endpackage : adcctl_pkg

//--- core/adcctl_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes asynchronous inputs and one system clock.
`timescale 1ns/1ns
`default_nettype none
module adcctl_sync #(
  parameter int           W       = 3,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : adcctl_sync
`default_nettype wire

//--- core/adcctl_core.sv
// Control-byte decoder and track/hold sequencer of a four-channel converter.
// Assumes serial pins from a host, sampled by the 100 MHz clk_i.
// How it works
// R1: Tracking starts on serial falling edge after fifth control bit.
// R2: Hold starts on serial falling edge after eighth control bit.
// R3: Single-ended mode ties negative input to common pin.
// R4: Differential mode ties negative input to paired minus channel.
// R5: After conversion end, hold capacitor reconnects to positive input.
// R6: First one after chip select falls is start bit, bit 7.
// R7: Bits 6 to 4 select the channels.
// R8: Bit 3 selects unipolar or bipolar.
// R9: Bit 2 one is single-ended, zero differential.
// R10: Host leaves at least 1.5 us between tracking and hold.
// R11: Bits 1 and 0 select clock mode and power-down.
// R12: Zeros before the start bit are ignored.
// R13: Data bits sampled on serial rising edge.
// R14: Unipolar results straight binary, bipolar two's complement.
`timescale 1ns/1ns
`default_nettype none
`include "adcctl_defs.svh"
module adcctl_core
  import adcctl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cs_n_i,
  input  wire logic       sclk_i,
  input  wire logic       din_i,
  input  wire logic       conv_done_i,
  output var  logic       track_o,
  output var  logic       hold_o,
  output var  logic       conv_start_o,
  output var  logic [1:0] pos_sel_o,
  output var  logic       neg_com_o,
  output var  logic [1:0] neg_sel_o,
  output var  logic       polarity_select_o,
  output var  logic       input_config_select_o,
  output var  logic       clock_power_mode_hi_o,
  output var  logic       clock_power_mode_lo_o,
  output var  logic       twos_complement_o,
  output var  logic       tacq_short_o
);
  typedef struct packed {
    adcctl_state_t st;
    logic          sclk_prev;
    logic [7:0]    shreg;
    logic [3:0]    cnt;
    logic [7:0]    ctrl;
    logic          track;
    logic          hold;
    logic          start;
    logic [7:0]    acq;
    logic          short_f;
  } adcctl_reg_t;

  adcctl_reg_t s_q;
  adcctl_reg_t s_d;
  logic [2:0]  pins;
  logic        cs_n_s;
  logic        sclk_s;
  logic        din_s;
  logic        rise;
  logic        fall;
  logic [2:0]  sel;
  logic [7:0]  acq_min;

  // Pin synchronisers, reset to the idle pin levels
  adcctl_sync #(
    .W       (3),
    .RST_VAL (3'h5)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({cs_n_i, sclk_i, din_i}),
    .q_o     (pins)
  );
  assign cs_n_s  = pins[2];
  assign sclk_s  = pins[1];
  assign din_s   = pins[0];
  // Serial clock edges
  assign rise    = sclk_s & ~s_q.sclk_prev;
  assign fall    = ~sclk_s & s_q.sclk_prev;
  assign acq_min = 8'(`ADCCTL_TACQ_CYC);

  // Positive channel per channel-select code
  function automatic logic [1:0] pos_of(input logic [2:0] c);
    case (c)
      3'h1:    pos_of = 2'h0;
      3'h5:    pos_of = 2'h1;
      3'h2:    pos_of = 2'h2;
      3'h6:    pos_of = 2'h3;
      default: pos_of = 2'h0;
    endcase
  endfunction : pos_of

  always_comb
  begin
    s_d = s_q;
    s_d.sclk_prev = sclk_s;
    s_d.start = 1'b0;
    // Acquisition counter, saturating
    if (s_q.track && s_q.acq != 8'hff)
    begin
      s_d.acq = s_q.acq + 8'h01;
    end
    // Conversion end releases hold
    if (conv_done_i && s_q.hold)
    begin
      s_d.hold = 1'b0; // R5
    end
    case (s_q.st)
      ADCCTL_IDLE:
      begin
        if (!cs_n_s && rise && din_s) // R6 R12 R13
        begin
          s_d.shreg = 8'h01;
          s_d.cnt   = 4'd1;
          s_d.st    = ADCCTL_SHIFT;
        end
      end
      ADCCTL_SHIFT:
      begin
        if (cs_n_s)
        begin
          s_d.st    = ADCCTL_IDLE;
          s_d.track = 1'b0;
        end
        else if (rise && s_q.cnt < `ADCCTL_BYTE_BITS)
        begin
          s_d.shreg = {s_q.shreg[6:0], din_s}; // R13
          s_d.cnt   = s_q.cnt + 4'd1;
        end
        else if (fall && s_q.cnt == `ADCCTL_TRACK_AFTER && !s_q.track)
        begin
          s_d.track = 1'b1; // R1
          s_d.hold  = 1'b0;
          s_d.acq   = 8'h00;
        end
        else if (fall && s_q.cnt == `ADCCTL_BYTE_BITS)
        begin
          s_d.track   = 1'b0; // R2
          s_d.hold    = 1'b1;
          s_d.start   = 1'b1;
          s_d.ctrl    = s_q.shreg;
          s_d.short_f = (s_q.acq < acq_min); // R10
          s_d.st      = ADCCTL_HOLD;
        end
      end
      ADCCTL_HOLD:
      begin
        if (cs_n_s || !s_q.hold)
        begin
          s_d.st = ADCCTL_IDLE;
        end
        else if (rise && din_s)
        begin
          s_d.shreg = 8'h01; // R6
          s_d.cnt   = 4'd1;
          s_d.hold  = 1'b0;
          s_d.st    = ADCCTL_SHIFT;
        end
      end
      default:
      begin
        s_d.st = ADCCTL_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '{
        st:        ADCCTL_IDLE,
        sclk_prev: 1'b0,
        shreg:     8'h00,
        cnt:       4'h0,
        ctrl:      `ADCCTL_CTRL_RESET,
        track:     1'b0,
        hold:      1'b0,
        start:     1'b0,
        acq:       8'h00,
        short_f:   1'b0
      };
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Input routing from the control byte
  assign sel = s_q.ctrl[`ADCCTL_BIT_SEL_MSB:`ADCCTL_BIT_SEL_LSB]; // R7
  always_comb
  begin
    pos_sel_o = pos_of(sel);
    neg_com_o = 1'b0;
    neg_sel_o = 2'h0;
    if (s_q.ctrl[`ADCCTL_BIT_INCONFIG]) // R9
    begin
      neg_com_o = 1'b1; // R3
    end
    else
    begin
      pos_sel_o = {sel[1], sel[2]}; // R4
      neg_sel_o = {sel[1], ~sel[2]}; // R4
    end
  end
  // Control fields and status
  assign track_o               = s_q.track;
  assign hold_o                = s_q.hold;
  assign conv_start_o          = s_q.start;
  assign polarity_select_o     = s_q.ctrl[`ADCCTL_BIT_POLARITY]; // R8
  assign twos_complement_o     = ~s_q.ctrl[`ADCCTL_BIT_POLARITY]; // R14
  assign input_config_select_o = s_q.ctrl[`ADCCTL_BIT_INCONFIG];
  assign clock_power_mode_hi_o = s_q.ctrl[1]; // R11
  assign clock_power_mode_lo_o = s_q.ctrl[0]; // R11
  assign tacq_short_o          = s_q.short_f;
endmodule : adcctl_core
`default_nettype wire

//--- verif/adcctl_assertions.sv
// Checker of track/hold and input routing.
// Sees only the core ports; bound from the bench top.
`timescale 1ns/1ns
`default_nettype none
module adcctl_assertions (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       cs_n_i,
  input wire logic       sclk_i,
  input wire logic       conv_done_i,
  input wire logic       track_o,
  input wire logic       hold_o,
  input wire logic       conv_start_o,
  input wire logic [1:0] pos_sel_o,
  input wire logic       neg_com_o,
  input wire logic [1:0] neg_sel_o,
  input wire logic       input_config_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_hold_entry;
    $rose(hold_o) ##0 conv_start_o;
  endsequence
  a_hold_pulse: assert property ($rose(hold_o) |-> conv_start_o ##1 !conv_start_o)
    else $error("start pulse");
  a_track_excl: assert property (!(track_o && hold_o))
    else $error("track with hold");
  a_track_fall: assert property ($rose(track_o) |-> !$past(sclk_i, 2))
    else $error("track edge");
  a_hold_after: assert property (s_hold_entry |-> $past(track_o) && !$past(sclk_i, 2))
    else $error("hold edge");
  a_done_clear: assert property (hold_o && conv_done_i |=> !hold_o)
    else $error("hold kept");
  a_cs_abort: assert property (cs_n_i [*4] |=> !track_o)
    else $error("track kept");
  a_single_com: assert property (hold_o && input_config_select_o |-> neg_com_o && neg_sel_o == 2'h0)
    else $error("single route");
  a_diff_pair: assert property (hold_o && !input_config_select_o |-> !neg_com_o
    && neg_sel_o == {pos_sel_o[1], ~pos_sel_o[0]})
    else $error("diff route");
  a_start_hold: assert property (conv_start_o |-> hold_o)
    else $error("start without hold");
endmodule : adcctl_assertions
`default_nettype wire

//--- verif/adcctl_host.sv
// Serial host model framing control bytes.
// Assumes the bench clock; pin clock idles low.
`timescale 1ns/1ns
`default_nettype none
module adcctl_host (
  input  wire logic clk_i,
  output var  logic cs_n_o,
  output var  logic sclk_o,
  output var  logic din_o
);
  initial {cs_n_o, sclk_o, din_o} = 3'h5;
  // Two zeros, then the first n bits of the byte, MSB first
  task automatic send(input logic [7:0] b, input logic slow, input int n);
    logic [9:0] w;
    int h;
    w = {2'h0, b};
    cs_n_o <= 1'b0;
    for (int i = 9; i >= 8 - n; i--)
    begin
      h = (slow && i < 3) ? 26 : 4;
      din_o <= w[i];
      repeat (h) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (h) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    din_o <= ~b[0];
    repeat (8) @(posedge clk_i);
  endtask : send
  task automatic stop();
    cs_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : stop
endmodule : adcctl_host
`default_nettype wire

//--- verif/adcctl_core_tb_top.sv
// Bench top: frames bytes through the host model.
// Assumes the core, host model and checker.
`timescale 1ns/1ns
`default_nettype none
module adcctl_core_tb_top;
  logic       clk_i = 1'b0, rst_n_i = 1'b0, conv_done_i = 1'b0;
  wire logic  cs_n_i, sclk_i, din_i;
  logic       track_o, hold_o, conv_start_o, neg_com_o, polarity_select_o, input_config_select_o;
  logic       clock_power_mode_hi_o, clock_power_mode_lo_o, twos_complement_o, tacq_short_o;
  logic [1:0] pos_sel_o, neg_sel_o;
  int         bad_count = 0;
  int         check_count = 0;
  int         starts = 0;
  int         base = 0;
  logic [7:0] tbl [8] = '{8'h9f, 8'hd4, 8'ha5, 8'hee, 8'h98, 8'ha1, 8'hda, 8'he3};
  initial forever #5 clk_i = ~clk_i;
  adcctl_host adcctl_host_i (.clk_i(clk_i), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .din_o(din_i));
  adcctl_core adcctl_core_i (
    .clk_i                 (clk_i),
    .rst_n_i               (rst_n_i),
    .cs_n_i                (cs_n_i),
    .sclk_i                (sclk_i),
    .din_i                 (din_i),
    .conv_done_i           (conv_done_i),
    .track_o               (track_o),
    .hold_o                (hold_o),
    .conv_start_o          (conv_start_o),
    .pos_sel_o             (pos_sel_o),
    .neg_com_o             (neg_com_o),
    .neg_sel_o             (neg_sel_o),
    .polarity_select_o     (polarity_select_o),
    .input_config_select_o (input_config_select_o),
    .clock_power_mode_hi_o (clock_power_mode_hi_o),
    .clock_power_mode_lo_o (clock_power_mode_lo_o),
    .twos_complement_o     (twos_complement_o),
    .tacq_short_o          (tacq_short_o)
  );
  // Counts conversion start pulses
  always @(posedge clk_i)
    if (conv_start_o === 1'b1)
      starts <= starts + 1;
  // Expected {pos, com, neg} per channel tables
  function automatic logic [4:0] exp_route(input logic [7:0] b);
    case ({b[2], b[6:4]})
      4'h9:    exp_route = 5'h04;
      4'hd:    exp_route = 5'h0c;
      4'ha:    exp_route = 5'h14;
      4'he:    exp_route = 5'h1c;
      4'h1:    exp_route = 5'h01;
      4'h2:    exp_route = 5'h13;
      4'h5:    exp_route = 5'h08;
      4'h6:    exp_route = 5'h1a;
      default: exp_route = 5'h00;
    endcase
  endfunction : exp_route
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [7:0] b);
    logic [4:0] dec;
    int         n0;
    n0 = starts;
    adcctl_host_i.send(b, 1'b1, 8);
    dec = {polarity_select_o, input_config_select_o, clock_power_mode_hi_o, clock_power_mode_lo_o, twos_complement_o};
    chk({11'h0, dec}, {11'h0, b[3:0], ~b[3]});
    chk({11'h0, pos_sel_o, neg_com_o, neg_sel_o}, {11'h0, exp_route(b)});
    chk({13'h0, track_o, hold_o, tacq_short_o}, 16'h0002);
    chk(16'(starts - n0), 16'h0001);
    conv_done_i <= 1'b1;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({15'h0, hold_o}, 16'h0);
    adcctl_host_i.stop();
    $display("test %h done", b);
  endtask : run
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    foreach (tbl[k]) run(tbl[k]);
    base = starts;
    adcctl_host_i.send(8'h9f, 1'b1, 6);
    chk({14'h0, track_o, hold_o}, 16'h0002);
    adcctl_host_i.stop();
    chk({14'h0, track_o, hold_o}, 16'h0000);
    chk({11'h0, pos_sel_o, neg_com_o, neg_sel_o}, {11'h0, exp_route(tbl[7])});
    chk(16'(starts - base), 16'h0000);
    $display("test abort done");
    base = starts;
    adcctl_host_i.send(8'h9f, 1'b0, 8);
    chk({14'h0, hold_o, tacq_short_o}, 16'h0003);
    adcctl_host_i.send(8'h9f, 1'b1, 1);
    chk({14'h0, track_o, hold_o}, 16'h0000);
    chk(16'(starts - base), 16'h0001);
    adcctl_host_i.stop();
    $display("test short done");
    wrap_up();
  end
  initial
  begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule : adcctl_core_tb_top
bind adcctl_core adcctl_assertions adcctl_assertions_i (
  .clk_i                 (clk_i),
  .rst_n_i               (rst_n_i),
  .cs_n_i                (cs_n_i),
  .sclk_i                (sclk_i),
  .conv_done_i           (conv_done_i),
  .track_o               (track_o),
  .hold_o                (hold_o),
  .conv_start_o          (conv_start_o),
  .pos_sel_o             (pos_sel_o),
  .neg_com_o             (neg_com_o),
  .neg_sel_o             (neg_sel_o),
  .input_config_select_o (input_config_select_o)
);
`default_nettype wire
